// ### hdl/ddc_data_space.sv
// Operation
// - Addresses 0x00-0x1F select the 32 working registers.
// - Next 64 addresses are standard I/O, then 160 extended I/O.
// - SRAM follows extended I/O; lower space spans 768/1280 locations.
// - Extended I/O is reachable only by loads/stores, not I/O-port accesses.
// - Direct addressing reaches the whole data space.
// - Displacement mode adds 0..63 to the Y or Z pointer.
// - Pointers X, Y, Z are register pairs 26..31.
// - Pre-decrement mode decrements the pointer and writes it back.
// - Post-increment mode increments the pointer after use and writes back.
// - Every addressing mode except the I/O-port form reaches all four regions.
// - An SRAM access completes in two clock cycles.
// - EEPROM is a separate byte-wide space of 512 bytes.
// - EEPROM address, data and control registers live in standard I/O.
// - Triggering an EEPROM read stalls the CPU four cycles.
// - Triggering an EEPROM write stalls the CPU two cycles.
// - Programming is self-timed; busy is readable by software.
// - A reset during programming lets the write finish.
// - Strobe counts only within four cycles of arm; arm self-clears.
// - Mode field picks atomic, erase or write; frozen while busy.
// - EEPROM addressed linearly; data register holds write and read byte.
`include "ddc_consts.svh"

module ddc_data_space #(
  parameter int unsigned P_ATOMIC_CYC = `DDC_T_ATOMIC_NS / `DDC_CLK_PERIOD_NS,
  parameter int unsigned P_SPLIT_CYC = `DDC_T_SPLIT_NS / `DDC_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire ddc_pkg::ddc_mode_e mode_i,
  input wire logic [1:0] ptr_sel_i,
  input wire logic [5:0] disp_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic done_o,
  output logic eep_busy_o
);

  function automatic ddc_pkg::ddc_region_e region_of(input logic [15:0] a);
    if (a < `DDC_SIO_BASE) begin
      return ddc_pkg::DDC_REG_RF;
    end else if (a < `DDC_EXT_BASE) begin
      return ddc_pkg::DDC_REG_SIO;
    end else if (a < `DDC_SRAM_BASE) begin
      return ddc_pkg::DDC_REG_EXT;
    end else if (a < `DDC_SRAM_END) begin
      return ddc_pkg::DDC_REG_SRAM;
    end else begin
      return ddc_pkg::DDC_REG_NONE;
    end
  endfunction : region_of

  ddc_pkg::ddc_state_e state_q, state_d;
  logic [7:0] rf_q [`DDC_RF_DEPTH];
  logic [7:0] sram_q [`DDC_SRAM_DEPTH];
  logic [15:0] acc_addr_q;
  logic we_q;
  logic [7:0] wdata_q;
  logic [2:0] stall_q, stall_d;
  logic done_q, done_d;
  logic [7:0] rdata_q;
  logic busy_q;

  // EEPROM access registers.
  logic [7:0] eedat_q;
  logic [8:0] eeadr_q;
  logic [1:0] pm_q;
  logic rie_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;

  logic take_w;
  logic exec_w;
  logic [4:0] ptr_lo_w;
  logic [4:0] ptr_hi_w;
  logic [15:0] ptr_w;
  logic [15:0] ptr_new_w;
  logic ptr_we_w;
  logic [15:0] eff_addr_w;
  ddc_pkg::ddc_region_e acc_reg_w;
  ddc_pkg::ddc_region_e eff_reg_w;
  logic [9:0] sram_idx_w;
  logic [7:0] rf_rd_w;
  logic rf_we_w;
  logic sram_we_w;
  logic ctl_wr_w;
  logic dat_wr_w;
  logic adl_wr_w;
  logic adh_wr_w;
  logic rd_trig_w;
  logic wr_trig_w;
  logic eep_busy_w;
  logic [7:0] eep_rdata_w;
  logic [7:0] ctl_rd_w;
  logic [7:0] io_rd_w;
  logic [7:0] rd_mux_w;

  assign take_w = (state_q == ddc_pkg::DDC_ST_IDLE) && req_i;
  assign exec_w = (state_q == ddc_pkg::DDC_ST_EXEC);

  // Pointer pair selection; code 3 falls back to Z.
  assign ptr_lo_w = (ptr_sel_i == 2'h0) ? `DDC_X_LO :
                    (ptr_sel_i == 2'h1) ? `DDC_Y_LO : `DDC_Z_LO;
  assign ptr_hi_w = ptr_lo_w + 5'h1;
  assign ptr_w = {rf_q[ptr_hi_w], rf_q[ptr_lo_w]};
  assign ptr_new_w = (mode_i == ddc_pkg::DDC_MODE_PREDEC) ?
                     ptr_w - 16'h0001 : ptr_w + 16'h0001;
  assign ptr_we_w = take_w && ((mode_i == ddc_pkg::DDC_MODE_PREDEC) ||
                    (mode_i == ddc_pkg::DDC_MODE_POSTINC));

  // All modes produce a full 16-bit address and share one decoder, so
  // every mode except the I/O-port form reaches every region.
  // The I/O-port form carries only six address bits, which keeps it out
  // of the extended range by construction.
  assign eff_addr_w =
    (mode_i == ddc_pkg::DDC_MODE_DIRECT) ? addr_i :
    (mode_i == ddc_pkg::DDC_MODE_IOPORT) ?
      ({10'h000, addr_i[5:0]} + `DDC_IO_OFS) :
    (mode_i == ddc_pkg::DDC_MODE_DISP) ?
      (ptr_w + {10'h000, disp_i}) :
    (mode_i == ddc_pkg::DDC_MODE_PREDEC) ? ptr_new_w :
    ptr_w;
  assign eff_reg_w = region_of(eff_addr_w);
  assign acc_reg_w = region_of(acc_addr_q);

  assign sram_idx_w = 10'(acc_addr_q - `DDC_SRAM_BASE);
  assign rf_rd_w = rf_q[acc_addr_q[4:0]];
  assign rf_we_w = exec_w && we_q && (acc_reg_w == ddc_pkg::DDC_REG_RF);
  assign sram_we_w = exec_w && we_q && (acc_reg_w == ddc_pkg::DDC_REG_SRAM);

  // EEPROM register hits sit inside the standard I/O window.
  // The decodes compare full data addresses below the extended range.
  assign ctl_wr_w = exec_w && we_q && (acc_addr_q == `DDC_EECTL_ADDR);
  assign dat_wr_w = exec_w && we_q && (acc_addr_q == `DDC_EEDAT_ADDR);
  assign adl_wr_w = exec_w && we_q && (acc_addr_q == `DDC_EEADL_ADDR);
  assign adh_wr_w = exec_w && we_q && (acc_addr_q == `DDC_EEADH_ADDR);
  assign rd_trig_w = ctl_wr_w && wdata_q[`DDC_CTL_RD_BIT] && !eep_busy_w;
  // The strobe only counts while the arm window is open and the engine
  // is idle; a strobe without arm is silently dropped. A read trigger in
  // the same write wins, so the engine must not start behind its stall.
  assign wr_trig_w = ctl_wr_w && wdata_q[`DDC_CTL_STRB_BIT] && arm_q &&
                     !eep_busy_w && !wdata_q[`DDC_CTL_RD_BIT];

  assign ctl_rd_w = {2'h0, pm_q, rie_q, arm_q, eep_busy_w, 1'b0};
  assign io_rd_w =
    (acc_addr_q == `DDC_EECTL_ADDR) ? ctl_rd_w :
    (acc_addr_q == `DDC_EEDAT_ADDR) ? eedat_q :
    (acc_addr_q == `DDC_EEADL_ADDR) ? eeadr_q[7:0] :
    (acc_addr_q == `DDC_EEADH_ADDR) ? {7'h00, eeadr_q[8]} : 8'h00;
  // Unimplemented I/O, extended I/O and unmapped space read as zero.
  assign rd_mux_w =
    (acc_reg_w == ddc_pkg::DDC_REG_RF) ? rf_rd_w :
    (acc_reg_w == ddc_pkg::DDC_REG_SRAM) ? sram_q[sram_idx_w] :
    (acc_reg_w == ddc_pkg::DDC_REG_SIO) ? io_rd_w : 8'h00;

  // Sequencer: take, execute, then an optional stall for EEPROM triggers.
  always_comb begin
    state_d = state_q;
    stall_d = stall_q;
    done_d = 1'b0;
    case (state_q)
      ddc_pkg::DDC_ST_IDLE: begin
        if (req_i) begin
          state_d = ddc_pkg::DDC_ST_EXEC;
        end
      end
      ddc_pkg::DDC_ST_EXEC: begin
        if (rd_trig_w) begin
          stall_d = `DDC_RD_STALL;
          state_d = ddc_pkg::DDC_ST_STALL;
        end else if (wr_trig_w) begin
          stall_d = `DDC_WR_STALL;
          state_d = ddc_pkg::DDC_ST_STALL;
        end else begin
          done_d = 1'b1;
          state_d = ddc_pkg::DDC_ST_IDLE;
        end
      end
      ddc_pkg::DDC_ST_STALL: begin
        stall_d = stall_q - 3'h1;
        if (stall_q == 3'h1) begin
          done_d = 1'b1;
          state_d = ddc_pkg::DDC_ST_IDLE;
        end
      end
      default: begin
        state_d = ddc_pkg::DDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ddc_pkg::DDC_ST_IDLE;
      stall_q <= 3'h0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      // Programming runs on through reset, so busy must stay visible.
      busy_q <= eep_busy_w;
    end else begin
      state_q <= state_d;
      stall_q <= stall_d;
      done_q <= done_d;
      busy_q <= eep_busy_w;
      if (exec_w && !we_q) begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (take_w) begin
      acc_addr_q <= eff_addr_w;
      we_q <= we_i;
      wdata_q <= wdata_i;
    end
  end

  // Pointer write-back happens at take, data writes one edge later, so
  // the two never collide on the register file.
  always_ff @(posedge clk_i) begin
    if (ptr_we_w) begin
      rf_q[ptr_lo_w] <= ptr_new_w[7:0];
      rf_q[ptr_hi_w] <= ptr_new_w[15:8];
    end
    if (rf_we_w) begin
      rf_q[acc_addr_q[4:0]] <= wdata_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sram_we_w) begin
      sram_q[sram_idx_w] <= wdata_q;
    end
  end

  // The arm window reloads on every write of a one to the arm bit.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (ctl_wr_w && wdata_q[`DDC_CTL_ARM_BIT]) begin
      arm_q <= 1'b1;
      arm_cnt_q <= `DDC_ARM_CYC;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
      arm_q <= (arm_cnt_q != 3'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      eedat_q <= `DDC_EEDAT_RST;
      eeadr_q <= 9'h000;
      rie_q <= 1'b0;
      if (!eep_busy_w) begin
        pm_q <= `DDC_PM_RST;
      end
    end else begin
      if (ctl_wr_w) begin
        rie_q <= wdata_q[`DDC_CTL_RIE_BIT];
        if (!eep_busy_w) begin
          pm_q <= wdata_q[`DDC_CTL_PM_LSB +: 2];
        end
      end
      if (dat_wr_w) begin
        eedat_q <= wdata_q;
      end else if (rd_trig_w) begin
        eedat_q <= eep_rdata_w;
      end
      if (adl_wr_w) begin
        eeadr_q[7:0] <= wdata_q;
      end
      if (adh_wr_w) begin
        eeadr_q[8] <= wdata_q[0];
      end
    end
  end

  ddc_eep_core #(
    .ATOMIC_CYC(P_ATOMIC_CYC),
    .SPLIT_CYC(P_SPLIT_CYC)
  ) u_eep (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(wr_trig_w),
    .mode_i(pm_q),
    .addr_i(eeadr_q),
    .wdata_i(eedat_q),
    .rdata_o(eep_rdata_w),
    .busy_o(eep_busy_w)
  );

  assign rdata_o = rdata_q;
  assign done_o = done_q;
  assign eep_busy_o = busy_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_wait_rd;
    !done_o [*4] ##1 done_o;
  endsequence
  sequence s_wait_wr;
    !done_o [*2] ##1 done_o;
  endsequence

  a_sram_two_cycle: assert property (
    (take_w && eff_reg_w == ddc_pkg::DDC_REG_SRAM) |=> !done_o ##1 done_o)
    else $error("SRAM access did not finish in two cycles.");
  a_rf_read_map: assert property (
    (exec_w && !we_q && acc_reg_w == ddc_pkg::DDC_REG_RF) |=>
    rdata_o == $past(rf_rd_w))
    else $error("Register file read returned wrong byte.");
  a_ioport_offset: assert property (
    (take_w && mode_i == ddc_pkg::DDC_MODE_IOPORT) |=>
    acc_addr_q < `DDC_EXT_BASE && acc_addr_q >= `DDC_SIO_BASE)
    else $error("I/O-port access left the standard I/O window.");
  a_disp_address: assert property (
    (take_w && mode_i == ddc_pkg::DDC_MODE_DISP) |=>
    acc_addr_q == $past(ptr_w) + {10'h000, $past(disp_i)})
    else $error("Displacement address wrong.");
  a_predec_ptr: assert property (
    (take_w && mode_i == ddc_pkg::DDC_MODE_PREDEC) |=>
    {rf_q[$past(ptr_hi_w)], rf_q[$past(ptr_lo_w)]} == $past(ptr_w) - 16'h1)
    else $error("Pre-decrement write-back wrong.");
  a_postinc_ptr: assert property (
    (take_w && mode_i == ddc_pkg::DDC_MODE_POSTINC) |=>
    acc_addr_q == $past(ptr_w) &&
    {rf_q[$past(ptr_hi_w)], rf_q[$past(ptr_lo_w)]} == $past(ptr_w) + 16'h1)
    else $error("Post-increment address or write-back wrong.");
  a_eep_read_stall: assert property (
    rd_trig_w |=> s_wait_rd)
    else $error("EEPROM read stall is not four cycles.");
  a_eep_write_stall: assert property (
    wr_trig_w |=> s_wait_wr)
    else $error("EEPROM write stall is not two cycles.");
  a_arm_self_clear: assert property (
    $rose(arm_q) |-> arm_q [*4] ##1 (!arm_q || $past(ctl_wr_w)))
    else $error("Arm bit did not clear after four cycles.");
  a_mode_frozen: assert property (
    (eep_busy_w && $past(eep_busy_w)) |-> $stable(pm_q))
    else $error("Mode field changed while programming.");

endmodule : ddc_data_space

// ### pkg/ddc_consts.svh
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

// Linear data space map, 1 KiB SRAM variant.
`define DDC_RF_BASE 16'h0000
`define DDC_SIO_BASE 16'h0020
`define DDC_EXT_BASE 16'h0060
`define DDC_SRAM_BASE 16'h0100
`define DDC_SRAM_END 16'h0500
`define DDC_SRAM_DEPTH 1024
`define DDC_RF_DEPTH 32
`define DDC_IO_OFS 16'h0020

// Index-register pairs (low byte location) inside the register file.
`define DDC_X_LO 5'h1a
`define DDC_Y_LO 5'h1c
`define DDC_Z_LO 5'h1e

// EEPROM access registers, as data space addresses.
`define DDC_EECTL_ADDR 16'h003f
`define DDC_EEDAT_ADDR 16'h0040
`define DDC_EEADL_ADDR 16'h0041
`define DDC_EEADH_ADDR 16'h0042
`define DDC_EEP_DEPTH 512

// Control register fields.
`define DDC_CTL_RD_BIT 0
`define DDC_CTL_STRB_BIT 1
`define DDC_CTL_ARM_BIT 2
`define DDC_CTL_RIE_BIT 3
`define DDC_CTL_PM_LSB 4
`define DDC_CTL_RST 8'h00
`define DDC_EEDAT_RST 8'h00
`define DDC_PM_RST 2'h0
`define DDC_ERASED_BYTE 8'hff

// Timing.
`define DDC_CLK_PERIOD_NS 10
`define DDC_T_ATOMIC_NS 3400000
`define DDC_T_SPLIT_NS 1800000
`define DDC_PROG_CNT_W 20
`define DDC_ARM_CYC 3'h4
`define DDC_RD_STALL 3'h4
`define DDC_WR_STALL 3'h2

`endif

// ### pkg/ddc_pkg.sv
package ddc_pkg;

  typedef enum logic [2:0] {
    DDC_MODE_DIRECT,
    DDC_MODE_DISP,
    DDC_MODE_IND,
    DDC_MODE_PREDEC,
    DDC_MODE_POSTINC,
    DDC_MODE_IOPORT
  } ddc_mode_e;

  typedef enum logic [2:0] {
    DDC_REG_RF,
    DDC_REG_SIO,
    DDC_REG_EXT,
    DDC_REG_SRAM,
    DDC_REG_NONE
  } ddc_region_e;

  typedef enum logic [1:0] {
    DDC_PM_ATOMIC = 2'h0,
    DDC_PM_ERASE = 2'h1,
    DDC_PM_WRITE = 2'h2,
    DDC_PM_RSVD = 2'h3
  } ddc_pm_e;

  typedef enum logic [1:0] {
    DDC_ST_IDLE,
    DDC_ST_EXEC,
    DDC_ST_STALL
  } ddc_state_e;

endpackage : ddc_pkg

// ### hdl/ddc_eep_core.sv
`include "ddc_consts.svh"

module ddc_eep_core #(
  parameter int unsigned ATOMIC_CYC = 340000,
  parameter int unsigned SPLIT_CYC = 180000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic busy_o
);

  logic [7:0] mem_q [`DDC_EEP_DEPTH];
  logic busy_q;
  logic [`DDC_PROG_CNT_W-1:0] cnt_q;
  logic [8:0] pa_q;
  logic [7:0] pd_q;
  logic [1:0] pm_q;
  logic go_w;
  logic fin_w;
  logic [7:0] new_byte_w;
  logic [`DDC_PROG_CNT_W-1:0] len_w;

  // Reserved mode code starts nothing.
  assign go_w = start_i && !busy_q && (mode_i != ddc_pkg::DDC_PM_RSVD);
  assign fin_w = busy_q && (cnt_q == `DDC_PROG_CNT_W'(1));
  assign len_w = (mode_i == ddc_pkg::DDC_PM_ATOMIC) ?
                 `DDC_PROG_CNT_W'(ATOMIC_CYC) : `DDC_PROG_CNT_W'(SPLIT_CYC);
  // Write-only can only clear bits of an erased cell.
  assign new_byte_w = (pm_q == ddc_pkg::DDC_PM_ATOMIC) ? pd_q :
                      (pm_q == ddc_pkg::DDC_PM_ERASE) ? `DDC_ERASED_BYTE :
                      (mem_q[pa_q] & pd_q);
  assign rdata_o = mem_q[addr_i];
  assign busy_o = busy_q;

  // A reset that lands mid-programming must not leave a half-written cell,
  // so the engine only honours reset while it is idle.
  always_ff @(posedge clk_i) begin
    if (!rstn_i && !busy_q) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      pa_q <= '0;
      pd_q <= '0;
      pm_q <= `DDC_PM_RST;
    end else if (go_w) begin
      busy_q <= 1'b1;
      cnt_q <= len_w;
      pa_q <= addr_i;
      pd_q <= wdata_i;
      pm_q <= mode_i;
    end else if (busy_q) begin
      cnt_q <= cnt_q - `DDC_PROG_CNT_W'(1);
      busy_q <= !fin_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (fin_w) begin
      mem_q[pa_q] <= new_byte_w;
    end
  end

  a_reset_keeps_prog: assert property (@(posedge clk_i)
    (busy_q && !rstn_i && cnt_q > `DDC_PROG_CNT_W'(1)) |=> busy_q)
    else $error("Programming aborted by reset.");

endmodule : ddc_eep_core

// ### verif/ddc_cpu_model.sv
// Stands in for the CPU core: one data access at a time on the access port.
module ddc_cpu_model (
  input wire logic clk_i,
  input wire logic done_i,
  input wire logic [7:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output ddc_pkg::ddc_mode_e mode_o,
  output logic [1:0] ptr_sel_o,
  output logic [5:0] disp_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    mode_o = ddc_pkg::DDC_MODE_DIRECT;
    ptr_sel_o = 2'h0;
    disp_o = 6'h00;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end

  task automatic present(input logic we, input ddc_pkg::ddc_mode_e md,
                         input logic [1:0] ps, input logic [5:0] dp,
                         input logic [15:0] ad, input logic [7:0] wd);
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    mode_o <= md;
    ptr_sel_o <= ps;
    disp_o <= dp;
    addr_o <= ad;
    wdata_o <= wd;
  endtask : present

  // The port is idle, so the request is taken at the next edge. A latency
  // of zero tells the caller that done never came.
  task automatic finish(output logic [7:0] rd, output int lat);
    @(posedge clk_i);
    req_o <= 1'b0;
    lat = 0;
    rd = 8'h00;
    for (int i = 1; i <= 40 && lat == 0; i++) begin
      @(posedge clk_i);
      if (done_i === 1'b1) begin
        lat = i;
        rd = rdata_i;
      end
    end
  endtask : finish

  task automatic access(input logic we, input ddc_pkg::ddc_mode_e md,
                        input logic [1:0] ps, input logic [5:0] dp,
                        input logic [15:0] ad, input logic [7:0] wd,
                        output logic [7:0] rd, output int lat);
    present(we, md, ps, dp, ad, wd);
    finish(rd, lat);
  endtask : access

  // Arm then strobe with no gap: the second store is presented in the
  // first one's done cycle, as an uninterruptible pair would be.
  task automatic arm_strobe(input logic [7:0] arm_v, input logic [7:0] stb_v,
                            output int lat);
    logic [7:0] rd;
    present(1'b1, ddc_pkg::DDC_MODE_DIRECT, 2'h0, 6'h00, 16'h003f,
            arm_v);
    @(posedge clk_i);
    req_o <= 1'b0;
    @(posedge clk_i);
    req_o <= 1'b1;
    wdata_o <= stb_v;
    finish(rd, lat);
  endtask : arm_strobe
endmodule : ddc_cpu_model

// ### verif/ddc_data_space_tb_top.sv
`define DDC_CHK(got, exp, what) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp); \
    end \
  end

module ddc_data_space_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req, we, done, busy;
  ddc_pkg::ddc_mode_e mode;
  logic [1:0] ptr_sel;
  logic [5:0] disp;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  int num_errors = 0;
  int n_compared = 0;
  int busy_cnt = 0;

  initial forever #5 clk_i = ~clk_i;

  always @(posedge clk_i) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

  ddc_data_space #(.P_ATOMIC_CYC(20), .P_SPLIT_CYC(10)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .we_i(we), .mode_i(mode),
    .ptr_sel_i(ptr_sel), .disp_i(disp), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata), .done_o(done), .eep_busy_o(busy));

  ddc_cpu_model cpu (
    .clk_i(clk_i), .done_i(done), .rdata_i(rdata), .req_o(req), .we_o(we),
    .mode_o(mode), .ptr_sel_o(ptr_sel), .disp_o(disp), .addr_o(addr),
    .wdata_o(wdata));

  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic acc(input logic w, input ddc_pkg::ddc_mode_e md,
                     input logic [1:0] ps, input logic [5:0] dp,
                     input logic [15:0] ad, input logic [7:0] wd,
                     input int exp_lat, output logic [7:0] rd);
    int lat;
    cpu.access(w, md, ps, dp, ad, wd, rd, lat);
    if (lat == 0) begin
      num_errors++;
      $display("MISMATCH at %0t: done never came", $time);
      stop_test();
    end else begin
      `DDC_CHK(lat, exp_lat, "access latency")
    end
  endtask : acc

  task automatic st(input logic [15:0] ad, input logic [7:0] wd,
                    input int l = 2);
    logic [7:0] rd;
    acc(1'b1, ddc_pkg::DDC_MODE_DIRECT, 2'h0, 6'h00, ad, wd, l, rd);
  endtask : st

  task automatic ldp(input ddc_pkg::ddc_mode_e md, input logic [1:0] ps,
                     input logic [5:0] dp, input logic [15:0] ad,
                     input logic [7:0] exp);
    logic [7:0] rd;
    acc(1'b0, md, ps, dp, ad, 8'h00, 2, rd);
    `DDC_CHK(rd, exp, "load data")
  endtask : ldp

  task automatic ld(input logic [15:0] ad, input logic [7:0] exp);
    ldp(ddc_pkg::DDC_MODE_DIRECT, 2'h0, 6'h00, ad, exp);
  endtask : ld

  task automatic eep_read(input logic [8:0] ea, input logic [7:0] exp);
    st(16'h0041, ea[7:0]);
    st(16'h0042, {7'h00, ea[8]});
    st(16'h003f, 8'h01, 6);
    ld(16'h0040, exp);
  endtask : eep_read

  // Waits for programming to end, then checks how long busy was up.
  task automatic busy_wait(input int b0, input int exp);
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_i);
    if (i == 400) begin
      num_errors++;
      $display("MISMATCH at %0t: busy never cleared", $time);
      stop_test();
    end else begin
      @(posedge clk_i);
      `DDC_CHK(busy_cnt - b0, exp, "busy length")
    end
  endtask : busy_wait

  task automatic t_map();
    logic [15:0] ads [9] = '{16'h0005, 16'h001f, 16'h0040, 16'h0041, 16'h0060,
                             16'h00ff, 16'h0100, 16'h04ff, 16'h0500};
    logic [7:0] exs [9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00,
                            8'h77, 8'h88, 8'h00};
    ld(16'h0040, 8'h00);
    ld(16'h003f, 8'h00);
    for (int i = 0; i < 9; i++) begin
      st(ads[i], 8'(8'h11 * (i + 1)));
    end
    for (int i = 0; i < 9; i++) begin
      ld(ads[i], exs[i]);
    end
    $display("t_map done");
  endtask : t_map

  task automatic t_ioport();
    logic [7:0] rd;
    acc(1'b1, ddc_pkg::DDC_MODE_IOPORT, 2'h0, 6'h00, 16'h0020, 8'ha7, 2, rd);
    ld(16'h0040, 8'ha7);
    st(16'h0041, 8'h12);
    ldp(ddc_pkg::DDC_MODE_IOPORT, 2'h0, 6'h00, 16'h0021, 8'h12);
    // Only six address bits reach the I/O space, so 0x60 folds onto 0x40.
    ldp(ddc_pkg::DDC_MODE_IOPORT, 2'h0, 6'h00, 16'h0060, 8'ha7);
    $display("t_ioport done");
  endtask : t_ioport

  task automatic t_ptr();
    st(16'h001c, 8'hf0);
    st(16'h001d, 8'h00);
    st(16'h012f, 8'h3c);
    ldp(ddc_pkg::DDC_MODE_DISP, 2'h1, 6'h3f, 16'h0000, 8'h3c);
    st(16'h001a, 8'h05);
    st(16'h001b, 8'h00);
    ldp(ddc_pkg::DDC_MODE_IND, 2'h0, 6'h00, 16'h0000, 8'h11);
    st(16'h001e, 8'h00);
    st(16'h001f, 8'h01);
    ldp(ddc_pkg::DDC_MODE_POSTINC, 2'h3, 6'h00, 16'h0000, 8'h77);
    ld(16'h001e, 8'h01);
    ldp(ddc_pkg::DDC_MODE_DISP, 2'h2, 6'h2e, 16'h0000, 8'h3c);
    st(16'h001c, 8'h00);
    st(16'h001d, 8'h01);
    ldp(ddc_pkg::DDC_MODE_PREDEC, 2'h1, 6'h00, 16'h0000, 8'h00);
    ld(16'h001c, 8'hff);
    ld(16'h001d, 8'h00);
    st(16'h0004, 8'h9a);
    ldp(ddc_pkg::DDC_MODE_PREDEC, 2'h0, 6'h00, 16'h0000, 8'h9a);
    ld(16'h001a, 8'h04);
    $display("t_ptr done");
  endtask : t_ptr

  task automatic t_eep_atomic();
    int lat;
    int b0;
    st(16'h0041, 8'hff);
    st(16'h0042, 8'h01);
    st(16'h0040, 8'h96);
    b0 = busy_cnt;
    cpu.arm_strobe(8'h04, 8'h02, lat);
    `DDC_CHK(lat, 4, "write stall")
    ld(16'h003f, 8'h02);
    st(16'h003f, 8'h10);
    cpu.arm_strobe(8'h04, 8'h02, lat);
    `DDC_CHK(lat, 2, "strobe while busy")
    busy_wait(b0, 20);
    ld(16'h003f, 8'h00);
    st(16'h0040, 8'h00);
    eep_read(9'h1ff, 8'h96);
    $display("t_eep_atomic done");
  endtask : t_eep_atomic

  task automatic t_eep_modes();
    logic [1:0] pm [3] = '{2'h1, 2'h2, 2'h3};
    logic [7:0] wd [3] = '{8'h00, 8'h0f, 8'h00};
    logic [7:0] ex [3] = '{8'hff, 8'h0f, 8'h0f};
    int dur [3] = '{10, 10, 0};
    int lat;
    int b0;
    for (int i = 0; i < 3; i++) begin
      st(16'h0040, wd[i]);
      b0 = busy_cnt;
      cpu.arm_strobe({2'h0, pm[i], 4'h4}, {2'h0, pm[i], 4'h2}, lat);
      `DDC_CHK(lat, 4, "mode write stall")
      busy_wait(b0, dur[i]);
      eep_read(9'h1ff, ex[i]);
    end
    st(16'h003f, 8'h08);
    ld(16'h003f, 8'h08);
    st(16'h003f, 8'h00);
    $display("t_eep_modes done");
  endtask : t_eep_modes

  task automatic t_window();
    int b0;
    st(16'h0040, 8'h21);
    b0 = busy_cnt;
    st(16'h003f, 8'h04);
    repeat (5) @(posedge clk_i);
    st(16'h003f, 8'h02);
    repeat (4) @(posedge clk_i);
    `DDC_CHK(busy_cnt - b0, 0, "late strobe programmed")
    $display("t_window done");
  endtask : t_window

  task automatic t_reset_mid();
    int lat;
    int b0;
    st(16'h0041, 8'h10);
    st(16'h0042, 8'h00);
    st(16'h0040, 8'h5c);
    b0 = busy_cnt;
    cpu.arm_strobe(8'h04, 8'h02, lat);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    `DDC_CHK(busy, 1'b1, "busy after reset")
    // A read trigger while programming is ignored and does not stall.
    st(16'h003f, 8'h01);
    busy_wait(b0, 20);
    eep_read(9'h010, 8'h5c);
    $display("t_reset_mid done");
  endtask : t_reset_mid

  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_map();
    t_ioport();
    t_ptr();
    t_eep_atomic();
    t_eep_modes();
    t_window();
    t_reset_mid();
    stop_test();
  end
endmodule : ddc_data_space_tb_top
